// *** rtl/dfr_cmd_unit.sv ***
`timescale 1ns/100ps
`include "dfr_defs.svh"
module dfr_cmd_unit (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               cmd_valid,
  input  wire dfr_pkg::dfr_cdb_t  cmd,
  output logic                    cmd_ready,
  output logic                    busy,
  output logic                    sts_valid,
  output logic              [7:0] sts_byte,
  input  wire logic               sts_ready,
  output dfr_pkg::dfr_sense_t     sense,
  input  wire logic        [20:0] max_lba,
  input  wire logic         [7:0] spt,
  output logic                    med_req_valid,
  output dfr_pkg::dfr_mreq_t      med_req,
  input  wire dfr_pkg::dfr_mrsp_t med_rsp,
  input  wire logic               med_positioned,
  input  wire logic               factory_defect_list,
  input  wire logic               med_wr_valid,
  input  wire logic         [7:0] med_wr_idx,
  input  wire logic         [7:0] med_wr_data,
  input  wire logic               pbuf_wr_valid,
  input  wire logic         [7:0] pbuf_wr_idx,
  input  wire logic         [7:0] pbuf_wr_data,
  input  wire logic               med_pat_rd,
  input  wire logic         [7:0] med_pat_idx,
  output logic              [7:0] med_pat_data,
  output logic                    dout_valid,
  output logic              [7:0] dout_data,
  input  wire logic               dout_ready
);
  import dfr_pkg::*;

  dfr_top_t    s_reg;
  dfr_top_t    s_next;
  logic [20:0] lba;
  logic        legal;
  logic        mem_re;
  logic [7:0]  mem_raddr;
  logic [7:0]  mem_rdata;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [20:0] nxt_trk;

  // Address field sits below three zero bits of byte 1
  assign lba     = {s_reg.cdb.b1[4:0], s_reg.cdb.b2, s_reg.cdb.b3};
  assign legal   = (s_reg.cdb.b1[7:5] == 3'h0) && (lba <= max_lba);
  assign nxt_trk = s_reg.cur + {13'h0000, spt};

  function automatic dfr_top_t fin(dfr_top_t t, logic [7:0] code, logic av,
                                   logic [20:0] a, logic [7:0] stb);
    dfr_top_t r;
    r                  = t;
    r.req_valid        = 1'b0;
    r.sense.code       = code;
    r.sense.addr_valid = av;
    r.sense.addr       = a;
    r.sts_valid        = 1'b1;
    r.sts_byte         = stb;
    r.state            = ST_STATUS;
    return r;
  endfunction

  function automatic dfr_top_t go(dfr_top_t t, dfr_state_t st, dfr_mop_t op,
                                  logic [20:0] a);
    dfr_top_t r;
    r           = t;
    r.state     = st;
    r.req_valid = 1'b1;
    r.mreq.op   = op;
    r.mreq.lba  = a;
    return r;
  endfunction

  always_comb begin
    s_next        = s_reg;
    mem_re        = med_pat_rd;
    mem_raddr     = med_pat_idx;
    fifo_in_valid = 1'b0;
    case (s_reg.state)
      ST_IDLE: begin
        if (cmd_valid) begin
          s_next.cdb       = cmd;
          s_next.busy      = 1'b1;
          s_next.cmd_ready = 1'b0;
          s_next.state     = ST_DECODE;
        end
      end
      ST_DECODE: begin
        s_next.mreq.ctrl = s_reg.cdb.b5[7:6];
        s_next.pat_sel   = s_reg.cdb.b5[`DFR_PAT_BIT];
        s_next.mreq.ilv  = (s_reg.cdb.b4 == 8'h00) ? `DFR_ILV_DEFAULT : s_reg.cdb.b4;
        s_next.ecc_seen  = 1'b0;
        case (s_reg.cdb.op)
          `DFR_OP_FORMAT, `DFR_OP_READ: begin
            if (!legal) begin
              s_next = fin(s_next, `DFR_SK_ADDR, 1'b0, 21'h000000, `DFR_ST_CHECK);
            end else if (s_reg.cdb.op == `DFR_OP_FORMAT) begin
              s_next = go(s_next, ST_RECAL, MOP_RECAL, lba);
            end else begin
              s_next.cur = lba;
              s_next.cnt = (s_reg.cdb.b4 == 8'h00) ? `DFR_MAX_BLOCKS
                                                   : {1'b0, s_reg.cdb.b4};
              if (med_positioned) begin
                s_next = go(s_next, ST_RSECT, MOP_READ, lba);
              end else begin
                s_next = go(s_next, ST_RSEEK, MOP_SEEK, lba);
              end
            end
          end
          `DFR_OP_CHKTRK, `DFR_OP_FMTTRK, `DFR_OP_FMTBAD: begin
            // Remaining bytes not examined
            s_next = fin(s_next, `DFR_SK_NONE, 1'b0, 21'h000000, `DFR_ST_GOOD);
          end
          default: begin
            s_next = fin(s_next, `DFR_SK_BADCMD, 1'b0, 21'h000000, `DFR_ST_CHECK);
          end
        endcase
      end
      ST_RECAL, ST_SEEK, ST_FMT, ST_VERIFY, ST_REMAP: begin
        if (med_rsp.done) begin
          s_next.req_valid = 1'b0;
          if (med_rsp.fatal) begin
            s_next = fin(s_next, med_rsp.code, 1'b1, med_rsp.fail_lba,
                         `DFR_ST_CHECK);
          end else begin
            case (s_reg.state)
              ST_RECAL: begin
                s_next.rem   = lba;
                s_next.state = ST_TRKCALC;
              end
              ST_SEEK: begin
                s_next.retried = 1'b0;
                s_next = go(s_next, ST_FMT, MOP_FMT, s_reg.cur);
              end
              ST_FMT: begin
                s_next = go(s_next, ST_VERIFY, MOP_VERIFY, s_reg.cur);
              end
              ST_VERIFY: begin
                if (med_rsp.bad && !s_reg.retried) begin
                  s_next.retried = 1'b1;
                  s_next = go(s_next, ST_FMT, MOP_FMT, s_reg.cur);
                end else if (med_rsp.bad || factory_defect_list) begin
                  s_next = go(s_next, ST_REMAP, MOP_REMAP, s_reg.cur);
                end else begin
                  s_next.state = ST_NEXTTRK;
                end
              end
              default: begin
                s_next.state = ST_NEXTTRK;
              end
            endcase
          end
        end
      end
      ST_TRKCALC: begin
        // Strip the in-track offset
        if ((spt != 8'h00) && (s_reg.rem >= {13'h0000, spt})) begin
          s_next.rem = s_reg.rem - {13'h0000, spt};
        end else begin
          s_next.cur = lba - s_reg.rem;
          s_next = go(s_next, ST_SEEK, MOP_SEEK, lba - s_reg.rem);
        end
      end
      ST_NEXTTRK: begin
        if ((nxt_trk > max_lba) || (spt == 8'h00)) begin
          s_next = fin(s_next, `DFR_SK_NONE, 1'b1, nxt_trk, `DFR_ST_GOOD);
        end else begin
          s_next.cur = nxt_trk;
          s_next = go(s_next, ST_SEEK, MOP_SEEK, nxt_trk);
        end
      end
      ST_RSEEK, ST_RSECT: begin
        if (med_rsp.done) begin
          s_next.req_valid = 1'b0;
          if (med_rsp.fatal) begin
            s_next = fin(s_next, med_rsp.code, 1'b1, s_reg.cur, `DFR_ST_CHECK);
          end else if (s_reg.state == ST_RSEEK) begin
            s_next = go(s_next, ST_RSECT, MOP_READ, s_reg.cur);
          end else begin
            s_next.ecc_now  = med_rsp.corrected;
            s_next.ecc_seen = s_reg.ecc_seen | med_rsp.corrected;
            s_next.didx     = 8'h00;
            s_next.dpend    = 1'b0;
            s_next.state    = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        mem_re    = !s_reg.dpend;
        mem_raddr = s_reg.didx;
        if (!s_reg.dpend) begin
          s_next.dpend = 1'b1;
        end else begin
          fifo_in_valid = 1'b1;
          if (fifo_in_ready) begin
            s_next.dpend = 1'b0;
            s_next.didx  = s_reg.didx + 8'h01;
            if (s_reg.didx == `DFR_LAST_BYTE) begin
              s_next.cnt = s_reg.cnt - 9'h001;
              if (s_reg.ecc_now && s_reg.mreq.ctrl[0]) begin
                s_next = fin(s_next, `DFR_SK_ECC, 1'b1, s_reg.cur, `DFR_ST_CHECK);
              end else if (s_reg.cnt == 9'h001) begin
                s_next = fin(s_next, s_reg.ecc_seen ? `DFR_SK_ECC : `DFR_SK_NONE, 1'b1,
                             s_reg.cur, `DFR_ST_GOOD);
              end else begin
                s_next.cur = s_reg.cur + 21'h000001;
                s_next = go(s_next, ST_RSECT, MOP_READ, s_reg.cur + 21'h000001);
              end
            end
          end
        end
      end
      ST_STATUS: begin
        if (sts_ready) begin
          s_next.sts_valid = 1'b0;
          s_next.busy      = 1'b0;
          s_next.cmd_ready = 1'b1;
          s_next.state     = ST_IDLE;
        end
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg           <= '0;
      s_reg.state     <= ST_IDLE;
      s_reg.cmd_ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  dfr_secbuf u_buf (
    .clk    (clk),
    .resetn (resetn),
    .we     (med_wr_valid || pbuf_wr_valid),
    .waddr  (med_wr_valid ? med_wr_idx : pbuf_wr_idx),
    .wdata  (med_wr_valid ? med_wr_data : pbuf_wr_data),
    .re     (mem_re),
    .raddr  (mem_raddr),
    .rdata  (mem_rdata)
  );

  dfr_fifo #(.W(8), .D(`DFR_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (fifo_in_valid),
    .in_data   (mem_rdata),
    .in_ready  (fifo_in_ready),
    .out_valid (dout_valid),
    .out_data  (dout_data),
    .out_ready (dout_ready)
  );

  assign med_pat_data  = s_reg.pat_sel ? mem_rdata : `DFR_FILL_BYTE;
  assign cmd_ready     = s_reg.cmd_ready;
  assign busy          = s_reg.busy;
  assign sts_valid     = s_reg.sts_valid;
  assign sts_byte      = s_reg.sts_byte;
  assign sense         = s_reg.sense;
  assign med_req_valid = s_reg.req_valid;
  assign med_req       = s_reg.mreq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_busy_till_status: assert property ((s_reg.state != ST_IDLE) |-> busy)
    else $error("busy dropped before status delivered");
  a_ack_good_status: assert property ((s_reg.state == ST_DECODE) && (s_reg.cdb.op >= 8'h05)
      && (s_reg.cdb.op <= 8'h07) |=> sts_valid && (sts_byte == 8'h00) && !med_req_valid)
    else $error("acknowledged opcode not answered good");
  a_recal_first: assert property ((s_reg.state == ST_DECODE) && legal
      && (s_reg.cdb.op == 8'h04) |=> med_req_valid && (med_req.op == MOP_RECAL))
    else $error("format did not start with recalibrate");
  a_fill_byte: assert property (med_pat_rd && !s_reg.pat_sel |=> med_pat_data == 8'h6C)
    else $error("wrong default fill byte");
  a_pat_buffer: assert property (med_pat_rd && s_reg.pat_sel |=> med_pat_data == mem_rdata)
    else $error("pattern not taken from sector buffer");
  a_ilv_default: assert property (med_req_valid && (med_req.op == MOP_FMT)
      && (s_reg.cdb.b4 == 8'h00) |-> med_req.ilv == 8'h02)
    else $error("zero interleave not mapped to two");
  a_blk_count: assert property ((s_reg.state == ST_DECODE) && legal && (s_reg.cdb.op == 8'h08)
      |=> s_reg.cnt == (($past(s_reg.cdb.b4) == 8'h00) ? 9'h100 : {1'b0, $past(s_reg.cdb.b4)}))
    else $error("block count decode wrong");
  a_one_reformat: assert property ((s_reg.state == ST_VERIFY) && med_rsp.done && med_rsp.bad
      && !med_rsp.fatal && s_reg.retried |=> s_reg.state == ST_REMAP)
    else $error("more than one reformat attempted");
  a_data_after_sector: assert property (fifo_in_valid |-> (s_reg.state == ST_DRAIN))
    else $error("data sent before sector buffered");
  a_illegal_addr: assert property ((s_reg.state == ST_DECODE) && !legal
      && ((s_reg.cdb.op == 8'h04) || (s_reg.cdb.op == 8'h08))
      |=> sense.code == 8'h21 ##0 sts_byte == 8'h02)
    else $error("illegal address not reported");
  a_next_sector: assert property ((s_reg.state == ST_NEXTTRK) && (nxt_trk > max_lba)
      |=> sense.addr == $past(nxt_trk) && sts_byte == 8'h00)
    else $error("format end address wrong");

  c_format_done: cover property ((s_reg.state == ST_NEXTTRK) ##1 sts_valid);
  c_reformat: cover property ((s_reg.state == ST_VERIFY) && s_reg.retried && med_rsp.done);
  c_multi_read: cover property ((s_reg.state == ST_DRAIN) && (s_reg.cnt > 9'h001)
      ##1 (s_reg.state == ST_DRAIN));
  c_ecc_stop: cover property (sts_valid && (sense.code == 8'h18) && (sts_byte == 8'h02));
endmodule

// *** rtl/dfr_defs.svh ***
`ifndef DFR_DEFS_SVH
`define DFR_DEFS_SVH
`define DFR_OP_FORMAT   8'h04
`define DFR_OP_CHKTRK   8'h05
`define DFR_OP_FMTTRK   8'h06
`define DFR_OP_FMTBAD   8'h07
`define DFR_OP_READ     8'h08
`define DFR_FILL_BYTE   8'h6C
`define DFR_PAT_BIT     5
`define DFR_NORETRY_BIT 7
`define DFR_ECCSTOP_BIT 6
`define DFR_ILV_DEFAULT 8'h02
`define DFR_SK_NONE     8'h00
`define DFR_SK_ECC      8'h18
`define DFR_SK_BADCMD   8'h20
`define DFR_SK_ADDR     8'h21
`define DFR_ST_GOOD     8'h00
`define DFR_ST_CHECK    8'h02
`define DFR_MAX_BLOCKS  9'h100
`define DFR_LAST_BYTE   8'hFF
`define DFR_FIFO_DEPTH  8
`endif

// *** rtl/dfr_pkg.sv ***
package dfr_pkg;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
  } dfr_cdb_t;

  typedef enum logic [2:0] {
    MOP_RECAL, MOP_SEEK, MOP_FMT, MOP_VERIFY, MOP_READ, MOP_REMAP
  } dfr_mop_t;

  typedef struct packed {
    dfr_mop_t    op;
    logic [20:0] lba;
    logic [7:0]  ilv;
    logic [1:0]  ctrl;
  } dfr_mreq_t;

  typedef struct packed {
    logic        done;
    logic        bad;
    logic        fatal;
    logic        corrected;
    logic [7:0]  code;
    logic [20:0] fail_lba;
  } dfr_mrsp_t;

  typedef struct packed {
    logic [7:0]  code;
    logic        addr_valid;
    logic [20:0] addr;
  } dfr_sense_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DECODE, ST_RECAL, ST_TRKCALC, ST_SEEK, ST_FMT, ST_VERIFY,
    ST_REMAP, ST_NEXTTRK, ST_RSEEK, ST_RSECT, ST_DRAIN, ST_STATUS
  } dfr_state_t;

  typedef struct packed {
    dfr_state_t  state;
    dfr_cdb_t    cdb;
    logic [20:0] cur;
    logic [20:0] rem;
    logic [8:0]  cnt;
    logic        retried;
    logic        ecc_seen;
    logic        ecc_now;
    logic        req_valid;
    dfr_mreq_t   mreq;
    dfr_sense_t  sense;
    logic        sts_valid;
    logic [7:0]  sts_byte;
    logic        busy;
    logic        cmd_ready;
    logic [7:0]  didx;
    logic        dpend;
    logic        pat_sel;
  } dfr_top_t;
endpackage

// *** rtl/dfr_secbuf.sv ***
`timescale 1ns/100ps
module dfr_secbuf (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic       re,
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:255];

  // Sector buffer, one sector, registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// *** rtl/dfr_fifo.sv ***
`timescale 1ns/100ps
module dfr_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rp_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** tb/dfr_media_model.sv ***
`timescale 1ns/100ps
module dfr_media_model (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               med_req_valid,
  input  wire dfr_pkg::dfr_mreq_t med_req,
  output dfr_pkg::dfr_mrsp_t      med_rsp,
  output logic                    factory_defect_list,
  output logic                    med_wr_valid,
  output logic              [7:0] med_wr_idx,
  output logic              [7:0] med_wr_data,
  output logic                    med_pat_rd,
  output logic              [7:0] med_pat_idx,
  input  wire logic         [7:0] med_pat_data
);
  import dfr_pkg::*;
  int          lat = 3;
  int          bad_left = 0;
  logic        fdl_on = 1'b0;
  logic        fatal_on = 1'b0;
  dfr_mop_t    fatal_op = MOP_FMT;
  logic [20:0] fatal_lba = 21'h0;
  logic [7:0]  fatal_code = 8'h00;
  logic        corr_on = 1'b0;
  logic        started = 1'b0;
  logic        seek_got = 1'b0;
  int          n_op [0:7] = '{default: 0};
  dfr_mop_t    first_op = MOP_SEEK;
  logic [20:0] seek_lba = 21'h0;
  logic [7:0]  ilv_seen = 8'h00;
  logic [7:0]  pat_seen = 8'h00;
  logic [1:0]  ctrl_seen = 2'h0;
  logic        ftl;
  dfr_mreq_t   r;
  assign factory_defect_list = fdl_on;
  initial begin
    med_rsp = '0;
    med_wr_valid = 1'b0;
    med_wr_idx = 8'h00;
    med_wr_data = 8'h00;
    med_pat_rd = 1'b0;
    med_pat_idx = 8'h00;
    forever begin
      @(posedge clk);
      if (resetn === 1'b1 && med_req_valid === 1'b1) begin
        r = med_req;
        ftl = fatal_on && r.op == fatal_op && r.lba == fatal_lba;
        if (!started) first_op = r.op;
        started = 1'b1;
        if (r.op == MOP_SEEK && !seek_got) seek_lba = r.lba;
        if (r.op == MOP_SEEK) seek_got = 1'b1;
        if (r.op == MOP_READ) ctrl_seen = r.ctrl;
        if (r.op == MOP_FMT) begin
          ilv_seen = r.ilv;
          med_pat_rd <= 1'b1;
          med_pat_idx <= 8'h03;
          @(posedge clk);
          med_pat_rd <= 1'b0;
          @(posedge clk);
          pat_seen = med_pat_data;
        end
        repeat (lat) @(posedge clk);
        if (r.op == MOP_READ && !ftl) begin
          for (int i = 0; i < 256; i++) begin
            med_wr_valid <= 1'b1;
            med_wr_idx <= i[7:0];
            med_wr_data <= r.lba[7:0] + i[7:0];
            @(posedge clk);
          end
        end
        med_wr_valid <= 1'b0;
        med_rsp.done <= 1'b1;
        med_rsp.bad <= r.op == MOP_VERIFY && bad_left > 0;
        med_rsp.fatal <= ftl;
        med_rsp.corrected <= corr_on && r.op == MOP_READ;
        med_rsp.code <= fatal_code;
        med_rsp.fail_lba <= r.lba + 21'h2;
        if (r.op == MOP_VERIFY && bad_left > 0) bad_left--;
        n_op[r.op]++;
        @(posedge clk);
        med_rsp <= '0;
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import dfr_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cmd_valid = 1'b0;
  dfr_cdb_t    cmd = '0;
  logic        cmd_ready, busy, sts_valid, med_req_valid, fdl, med_wr_valid, med_pat_rd;
  logic [7:0]  sts_byte, med_wr_idx, med_wr_data, med_pat_idx, med_pat_data, dout_data;
  logic        sts_ready = 1'b0;
  dfr_sense_t  sense, sn;
  dfr_mreq_t   med_req;
  dfr_mrsp_t   med_rsp;
  logic        med_positioned = 1'b0;
  logic        pbuf_wr_valid = 1'b0;
  logic [7:0]  pbuf_wr_idx = 8'h00;
  logic [7:0]  pbuf_wr_data = 8'h00;
  logic        dout_valid;
  logic        dout_ready = 1'b0;
  logic [7:0]  st;
  logic [7:0]  q [$];
  logic [4:0]  stall = 5'h00;
  logic        early = 1'b0;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc;
  int          snap [0:7];
  always #12.5 clk = ~clk;
  dfr_cmd_unit dfr_cmd_unit_i (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .busy(busy), .sts_valid(sts_valid), .sts_byte(sts_byte),
    .sts_ready(sts_ready), .sense(sense), .max_lba(21'h00000B), .spt(8'h04),
    .med_req_valid(med_req_valid), .med_req(med_req), .med_rsp(med_rsp),
    .med_positioned(med_positioned), .factory_defect_list(fdl),
    .med_wr_valid(med_wr_valid), .med_wr_idx(med_wr_idx), .med_wr_data(med_wr_data),
    .pbuf_wr_valid(pbuf_wr_valid), .pbuf_wr_idx(pbuf_wr_idx), .pbuf_wr_data(pbuf_wr_data),
    .med_pat_rd(med_pat_rd), .med_pat_idx(med_pat_idx), .med_pat_data(med_pat_data),
    .dout_valid(dout_valid), .dout_data(dout_data), .dout_ready(dout_ready));
  dfr_media_model dfr_media_model_i (.clk(clk), .resetn(resetn),
    .med_req_valid(med_req_valid), .med_req(med_req), .med_rsp(med_rsp),
    .factory_defect_list(fdl), .med_wr_valid(med_wr_valid), .med_wr_idx(med_wr_idx),
    .med_wr_data(med_wr_data), .med_pat_rd(med_pat_rd), .med_pat_idx(med_pat_idx),
    .med_pat_data(med_pat_data));
  always @(posedge clk) begin
    stall <= stall + 5'h01;
    dout_ready <= ~stall[4];
    if (dout_valid === 1'b1 && dout_ready === 1'b1) begin
      if (dfr_media_model_i.n_op[MOP_READ] == snap[MOP_READ]) early <= 1'b1;
      q.push_back(dout_data);
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic int d(input dfr_mop_t o);
    return dfr_media_model_i.n_op[o] - snap[o];
  endfunction
  task automatic run(input dfr_cdb_t c, input logic [7:0] est, input logic [7:0] ecode,
                     input logic eav, input logic [20:0] eaddr);
    @(posedge clk);
    snap = dfr_media_model_i.n_op;
    dfr_media_model_i.started = 1'b0;
    dfr_media_model_i.seek_got = 1'b0;
    q.delete();
    early = 1'b0;
    cmd <= c;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cyc = 0;
    while (sts_valid !== 1'b1 && cyc < 20000) begin
      @(posedge clk);
      cyc++;
      if (sts_valid !== 1'b1) chk("busy while running", 1, busy);
    end
    chk("status seen", 1, sts_valid);
    st = sts_byte;
    sn = sense;
    sts_ready <= 1'b1;
    @(posedge clk);
    sts_ready <= 1'b0;
    @(posedge clk);
    chk("busy after status", 0, busy);
    chk("status byte", est, st);
    chk("sense code", ecode, sn.code);
    chk("address valid", eav, sn.addr_valid);
    if (eav) chk("sense address", eaddr, sn.addr);
    repeat (40) @(posedge clk);
  endtask
  task automatic qchk(input logic [7:0] lba0, input int nblk);
    chk("byte count", nblk * 256, q.size());
    for (int i = 0; i < q.size() && i < nblk * 256; i++) begin
      chk("read byte", 8'(lba0 + i / 256 + i % 256), {24'h0, q[i]});
    end
    chk("early data", 0, early);
  endtask
  task automatic t_ack();
    for (int k = 5; k <= 7; k++) begin
      run({k[7:0], 40'hFF_FF_FF_FF_FF}, 8'h00, 8'h00, 1'b0, 21'h0);
      chk("ack latency", 2, cyc);
      chk("ack media ops", 0, d(MOP_SEEK) + d(MOP_RECAL) + d(MOP_FMT));
    end
  endtask
  task automatic t_illegal();
    run(48'h08_E0_00_00_01_00, 8'h02, 8'h21, 1'b0, 21'h0);
    chk("refused media ops", 0, d(MOP_READ) + d(MOP_SEEK));
    run(48'h08_00_00_0C_01_00, 8'h02, 8'h21, 1'b0, 21'h0);
    chk("refused media ops", 0, d(MOP_READ) + d(MOP_SEEK));
    run(48'h3F_00_00_00_00_00, 8'h02, 8'h20, 1'b0, 21'h0);
    chk("refused media ops", 0, d(MOP_READ) + d(MOP_SEEK));
  endtask
  task automatic fmt_counts(input int f, input int v, input int m);
    chk("format ops", f, d(MOP_FMT));
    chk("verify ops", v, d(MOP_VERIFY));
    chk("remap ops", m, d(MOP_REMAP));
  endtask
  task automatic t_fmt_plain();
    run(48'h04_00_00_05_00_00, 8'h00, 8'h00, 1'b1, 21'h0C);
    chk("first op", MOP_RECAL, dfr_media_model_i.first_op);
    chk("recal ops", 1, d(MOP_RECAL));
    chk("start track", 4, dfr_media_model_i.seek_lba);
    chk("interleave", 2, dfr_media_model_i.ilv_seen);
    chk("pattern", 8'h6C, dfr_media_model_i.pat_seen);
    fmt_counts(2, 2, 0);
  endtask
  task automatic t_fmt_pattern();
    @(posedge clk);
    pbuf_wr_valid <= 1'b1;
    pbuf_wr_idx <= 8'h03;
    pbuf_wr_data <= 8'hA5;
    @(posedge clk);
    pbuf_wr_valid <= 1'b0;
    dfr_media_model_i.bad_left = 1;
    run(48'h04_00_00_00_03_20, 8'h00, 8'h00, 1'b1, 21'h0C);
    chk("pattern", 8'hA5, dfr_media_model_i.pat_seen);
    chk("interleave", 3, dfr_media_model_i.ilv_seen);
    fmt_counts(4, 4, 0);
    dfr_media_model_i.bad_left = 2;
    run(48'h04_00_00_09_00_00, 8'h00, 8'h00, 1'b1, 21'h0C);
    fmt_counts(2, 2, 1);
  endtask
  task automatic t_fmt_abort();
    dfr_media_model_i.fdl_on = 1'b1;
    dfr_media_model_i.fatal_on = 1'b1;
    dfr_media_model_i.fatal_op = MOP_FMT;
    dfr_media_model_i.fatal_lba = 21'h8;
    dfr_media_model_i.fatal_code = 8'h1A;
    run(48'h04_00_00_00_00_00, 8'h02, 8'h1A, 1'b1, 21'h0A);
    fmt_counts(3, 2, 2);
    dfr_media_model_i.fdl_on = 1'b0;
    dfr_media_model_i.fatal_on = 1'b0;
  endtask
  task automatic t_read();
    run(48'h08_00_00_07_02_C0, 8'h00, 8'h00, 1'b1, 21'h08);
    chk("seek ops", 1, d(MOP_SEEK));
    chk("read ops", 2, d(MOP_READ));
    chk("control bits", 3, dfr_media_model_i.ctrl_seen);
    qchk(8'h07, 2);
    med_positioned <= 1'b1;
    dfr_media_model_i.fatal_on = 1'b1;
    dfr_media_model_i.fatal_op = MOP_READ;
    dfr_media_model_i.fatal_lba = 21'h3;
    dfr_media_model_i.fatal_code = 8'h11;
    run(48'h08_00_00_01_00_00, 8'h02, 8'h11, 1'b1, 21'h03);
    chk("seek ops", 0, d(MOP_SEEK));
    chk("read ops", 3, d(MOP_READ));
    qchk(8'h01, 2);
    dfr_media_model_i.fatal_on = 1'b0;
    dfr_media_model_i.corr_on = 1'b1;
    run(48'h08_00_00_09_01_00, 8'h00, 8'h18, 1'b1, 21'h09);
    run(48'h08_00_00_09_02_40, 8'h02, 8'h18, 1'b1, 21'h09);
    chk("control bits", 1, dfr_media_model_i.ctrl_seen);
    qchk(8'h09, 1);
    dfr_media_model_i.corr_on = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(60000 * 25);
    mismatches++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    chk("ready after reset", 1, cmd_ready);
    t_ack();
    t_illegal();
    t_fmt_plain();
    t_fmt_pattern();
    t_fmt_abort();
    t_read();
    close_out();
  end
endmodule
